// file: charger_cfg_pkg.sv
// Register map, field positions and per-variant defaults of the charger register bank
package charger_cfg_pkg;
  localparam logic [7:0] ADDR_CTRL_MAIN = 8'h02;
  localparam logic [7:0] ADDR_CUR_SCALE = 8'h03;
  localparam logic [7:0] ADDR_TMR_SENS = 8'h04;
  localparam logic [7:0] ADDR_VOLT_TEMP = 8'h05;
  localparam logic [7:0] ADDR_STATE = 8'h06;

  // Writable bits of each register
  localparam logic [7:0] MASK_CTRL_MAIN = 8'hFF;
  localparam logic [7:0] MASK_CUR_SCALE = 8'hFC;
  localparam logic [7:0] MASK_TMR_SENS = 8'hEE;
  localparam logic [7:0] MASK_VOLT_TEMP = 8'hFE;

  // Product variants
  localparam int VARIANT_BASE = 0;
  localparam int VARIANT_LOW_CUR = 1;
  localparam int VARIANT_LOW_IN = 2;
  localparam int VARIANT_EXT = 3;

  // Values after reset or supply lockout
  localparam logic [7:0] DEF_CTRL_MAIN_BASE = 8'h6F;
  localparam logic [7:0] DEF_CTRL_MAIN_LOW_IN = 8'h4F;
  localparam logic [7:0] DEF_CTRL_MAIN_EXT = 8'hAF;
  localparam logic [7:0] DEF_CUR_SCALE_BASE = 8'h54;
  localparam logic [7:0] DEF_CUR_SCALE_EXT = 8'h77;
  localparam logic [7:0] DEF_TMR_SENS = 8'h4C;
  localparam logic [7:0] DEF_VOLT_TEMP = 8'h40;

  // Field positions
  localparam int POS_SYS_SEL = 6;
  localparam int POS_LIMIT_SEL = 4;
  localparam int POS_THERMAL = 3;
  localparam int POS_ADAPT_TMR = 2;
  localparam int POS_TERM_EN = 1;
  localparam int POS_CHG_EN = 0;
  localparam int POS_PRE_FACTOR = 6;
  localparam int POS_FAST_SCALE = 4;
  localparam int POS_TERM_FACTOR = 2;
  localparam int POS_SAFETY_TMR = 6;
  localparam int POS_PRECHARGE_TIMER_SELECT = 5;
  localparam int POS_THERMISTOR = 3;
  localparam int POS_PATH_THR = 2;
  localparam int POS_CMP_EN = 1;
  localparam int POS_CHG_VOLT = 5;
  localparam int POS_TEMP_OFS = 3;
  localparam int POS_TRIP = 1;
  localparam int POS_CMP_OUT = 0;

  // Codes with special meaning
  localparam logic [1:0] SYS_TRACK_BAT = 2'b00;
  localparam logic [1:0] LIMIT_100_DYNAMIC_PATH_MANAGEMENT = 2'b00;
  localparam logic [1:0] LIMIT_500_DYNAMIC_PATH_MANAGEMENT = 2'b01;
  localparam logic [1:0] LIMIT_SUSPEND = 2'b11;
endpackage : charger_cfg_pkg

// file: charger_config_status_regs.sv
// Charger configuration and state register bank behind the serial register port
// How it works
// [RL1] SYS select: 00 tracks battery and forces path threshold high; 01/10/11 fixed.
// [RL2] Input limit codes 00/01 use input DYNAMIC_PATH_MANAGEMENT; 10 is 500 mA without it.
// [RL3] Input limit code 11 puts the charger into USB suspend standby.
// [RL4] Thermal regulation bit enables current reduction above die limit.
// [RL5] Adaptive timer bit slows safety timer while current is being limited.
// [RL6] Termination bit clear means charging never terminates.
// [RL7] Charger enable bit turns the charger off at zero, on at one.
// [RL8] Precharge factor picks 5 to 20 percent of scaled current.
// [RL9] Fast-charge scale picks 25 to 100 percent, timer scales inversely.
// [RL10] Termination factor picks 5 to 20 percent of scaled current.
// [RL11] Safety timer field picks 4, 5, 6 or 8 hours.
// [RL12] Precharge timer bit picks 30 or 60 minutes.
// [RL13] Thermistor bit picks 100k low bias or 10k high bias sensor.
// [RL14] Path threshold bit picks battery plus 100 mV or fixed 4.3 V.
// [RL15] Comparator enable clear disables the cell comparator and its interrupt.
// [RL16] Charge voltage field picks 4.15 V to 4.325 V in 25 mV steps.
// [RL17] Temperature offset shifts the cold/hot window in 5 degree steps.
// [RL18] Trip level field picks 2.2 V to 2.5 V comparator threshold.
// [RL19] Comparator bit reads one when below trip or comparator disabled.
// [RL20] State register shows eight live charger state flags.
// [RL21] Writable fields reload defaults on lockout or reset; unused bits read-only.
// [RL22] Reads of unmapped addresses return zero.
// [RL23] Defaults are restored while the supply lockout is asserted.
// [RL24] Variant defaults are chosen by a build-time parameter.
`timescale 1ns/1ps
module charger_config_status_regs #(
  parameter int VARIANT = charger_cfg_pkg::VARIANT_BASE
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic supply_lockout,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [7:0] charger_state,
  input wire logic cell_below_trip,
  output logic [1:0] sys_rail_select,
  output logic sys_track_battery,
  output logic [1:0] input_limit_select,
  output logic input_dynamic_path_management_enable,
  output logic usb_suspend,
  output logic thermal_regulation_enable,
  output logic adaptive_timer_enable,
  output logic termination_enable,
  output logic charger_enable,
  output logic [1:0] precharge_factor,
  output logic [1:0] fastcharge_scale,
  output logic [1:0] termination_factor,
  output logic [1:0] safety_timer_select,
  output logic precharge_timer_select,
  output logic thermistor_type,
  output logic power_path_threshold_select,
  output logic cell_comparator_enable,
  output logic [2:0] charge_voltage_select,
  output logic [1:0] temp_window_offset,
  output logic [1:0] cell_trip_level
);
  // Variant default selection
  localparam logic [7:0] DEF_CTRL = (VARIANT == charger_cfg_pkg::VARIANT_EXT) ? charger_cfg_pkg::DEF_CTRL_MAIN_EXT :
    (VARIANT == charger_cfg_pkg::VARIANT_LOW_IN) ? charger_cfg_pkg::DEF_CTRL_MAIN_LOW_IN :
    charger_cfg_pkg::DEF_CTRL_MAIN_BASE; // RL24
  localparam logic [7:0] DEF_SCALE = (VARIANT == charger_cfg_pkg::VARIANT_EXT) ? charger_cfg_pkg::DEF_CUR_SCALE_EXT :
    charger_cfg_pkg::DEF_CUR_SCALE_BASE; // RL24
  localparam logic [7:0] RO_SCALE = DEF_SCALE & ~charger_cfg_pkg::MASK_CUR_SCALE;

  logic rst_meta_r;
  logic rst_n_r;
  logic lock_meta_r;
  logic lock_r;
  logic cmp_meta_r;
  logic cmp_r;
  logic [7:0] ctrl_r;
  logic [7:0] scale_r;
  logic [7:0] tmr_r;
  logic [7:0] volt_r;
  logic suspend_r;
  logic dynamic_path_management_r;
  logic track_r;
  logic path_thr_r;
  logic [7:0] rdata_r;
  logic rvalid_r;

  // Reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Pin inputs synchronised
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lock_meta_r <= 1'b1;
      lock_r <= 1'b1;
      cmp_meta_r <= 1'b0;
      cmp_r <= 1'b0;
    end else begin
      lock_meta_r <= supply_lockout;
      lock_r <= lock_meta_r;
      cmp_meta_r <= cell_below_trip;
      cmp_r <= cmp_meta_r;
    end
  end

  // Write decode
  wire wr_ok = reg_wr && !lock_r;
  wire wr_ctrl = wr_ok && (reg_addr == charger_cfg_pkg::ADDR_CTRL_MAIN);
  wire wr_scale = wr_ok && (reg_addr == charger_cfg_pkg::ADDR_CUR_SCALE);
  wire wr_tmr = wr_ok && (reg_addr == charger_cfg_pkg::ADDR_TMR_SENS);
  wire wr_volt = wr_ok && (reg_addr == charger_cfg_pkg::ADDR_VOLT_TEMP);

  wire [7:0] ctrl_nxt = lock_r ? DEF_CTRL : (wr_ctrl ? reg_wdata : ctrl_r); // RL21 RL23
  wire [7:0] scale_nxt = lock_r ? DEF_SCALE :
    (wr_scale ? ((reg_wdata & charger_cfg_pkg::MASK_CUR_SCALE) | RO_SCALE) : scale_r); // RL21 RL23
  wire [7:0] tmr_nxt = lock_r ? charger_cfg_pkg::DEF_TMR_SENS :
    (wr_tmr ? (reg_wdata & charger_cfg_pkg::MASK_TMR_SENS) : tmr_r); // RL21 RL23
  wire [7:0] volt_nxt = lock_r ? charger_cfg_pkg::DEF_VOLT_TEMP :
    (wr_volt ? (reg_wdata & charger_cfg_pkg::MASK_VOLT_TEMP) : volt_r); // RL21 RL23

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r <= DEF_CTRL; // RL21
      scale_r <= DEF_SCALE;
      tmr_r <= charger_cfg_pkg::DEF_TMR_SENS;
      volt_r <= charger_cfg_pkg::DEF_VOLT_TEMP;
    end else begin
      ctrl_r <= ctrl_nxt;
      scale_r <= scale_nxt;
      tmr_r <= tmr_nxt;
      volt_r <= volt_nxt;
    end
  end

  // Derived controls
  wire [1:0] sys_nxt = ctrl_nxt[charger_cfg_pkg::POS_SYS_SEL +: 2];
  wire [1:0] lim_nxt = ctrl_nxt[charger_cfg_pkg::POS_LIMIT_SEL +: 2];
  wire track_nxt = (sys_nxt == charger_cfg_pkg::SYS_TRACK_BAT); // RL1
  wire suspend_nxt = (lim_nxt == charger_cfg_pkg::LIMIT_SUSPEND); // RL3
  wire dynamic_path_management_nxt = (lim_nxt == charger_cfg_pkg::LIMIT_100_DYNAMIC_PATH_MANAGEMENT) || (lim_nxt == charger_cfg_pkg::LIMIT_500_DYNAMIC_PATH_MANAGEMENT); // RL2
  wire path_thr_nxt = tmr_nxt[charger_cfg_pkg::POS_PATH_THR] || track_nxt; // RL1 RL14

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      suspend_r <= 1'b0;
      dynamic_path_management_r <= 1'b0;
      track_r <= 1'b0;
      path_thr_r <= 1'b1;
    end else begin
      suspend_r <= suspend_nxt;
      dynamic_path_management_r <= dynamic_path_management_nxt;
      track_r <= track_nxt;
      path_thr_r <= path_thr_nxt;
    end
  end

  // Read decode
  wire cmp_en = tmr_r[charger_cfg_pkg::POS_CMP_EN];
  wire cmp_bit = !tmr_r[charger_cfg_pkg::POS_CMP_EN] || cmp_r; // RL19 RL15
  wire [7:0] rd_mux =
    (reg_addr == charger_cfg_pkg::ADDR_CTRL_MAIN) ? ctrl_r :
    (reg_addr == charger_cfg_pkg::ADDR_CUR_SCALE) ? scale_r :
    (reg_addr == charger_cfg_pkg::ADDR_TMR_SENS) ? tmr_r :
    (reg_addr == charger_cfg_pkg::ADDR_VOLT_TEMP) ? {volt_r[7:1], cmp_bit} :
    (reg_addr == charger_cfg_pkg::ADDR_STATE) ? charger_state : // RL20
    8'h00; // RL22

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd;
      if (reg_rd) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign sys_rail_select = ctrl_r[charger_cfg_pkg::POS_SYS_SEL +: 2]; // RL1
  assign sys_track_battery = track_r;
  assign input_limit_select = ctrl_r[charger_cfg_pkg::POS_LIMIT_SEL +: 2]; // RL2
  assign input_dynamic_path_management_enable = dynamic_path_management_r;
  assign usb_suspend = suspend_r;
  assign thermal_regulation_enable = ctrl_r[charger_cfg_pkg::POS_THERMAL]; // RL4
  assign adaptive_timer_enable = ctrl_r[charger_cfg_pkg::POS_ADAPT_TMR]; // RL5
  assign termination_enable = ctrl_r[charger_cfg_pkg::POS_TERM_EN]; // RL6
  assign charger_enable = ctrl_r[charger_cfg_pkg::POS_CHG_EN]; // RL7
  assign precharge_factor = scale_r[charger_cfg_pkg::POS_PRE_FACTOR +: 2]; // RL8
  assign fastcharge_scale = scale_r[charger_cfg_pkg::POS_FAST_SCALE +: 2]; // RL9
  assign termination_factor = scale_r[charger_cfg_pkg::POS_TERM_FACTOR +: 2]; // RL10
  assign safety_timer_select = tmr_r[charger_cfg_pkg::POS_SAFETY_TMR +: 2]; // RL11
  assign precharge_timer_select = tmr_r[charger_cfg_pkg::POS_PRECHARGE_TIMER_SELECT]; // RL12
  assign thermistor_type = tmr_r[charger_cfg_pkg::POS_THERMISTOR]; // RL13
  assign power_path_threshold_select = path_thr_r; // RL14
  assign cell_comparator_enable = tmr_r[charger_cfg_pkg::POS_CMP_EN]; // RL15
  assign charge_voltage_select = volt_r[charger_cfg_pkg::POS_CHG_VOLT +: 3]; // RL16
  assign temp_window_offset = volt_r[charger_cfg_pkg::POS_TEMP_OFS +: 2]; // RL17
  assign cell_trip_level = volt_r[charger_cfg_pkg::POS_TRIP +: 2]; // RL18

  // Checks
  property p_unmapped_zero;
    @(posedge clk) disable iff (!rst_n_r)
    reg_rd && (reg_addr > charger_cfg_pkg::ADDR_STATE || reg_addr < charger_cfg_pkg::ADDR_CTRL_MAIN)
      |=> reg_rvalid && reg_rdata == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero"); // RL22

  property p_ctrl_write;
    @(posedge clk) disable iff (!rst_n_r)
    reg_wr && !lock_r && reg_addr == charger_cfg_pkg::ADDR_CTRL_MAIN |=> charger_enable == $past(reg_wdata[0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("charger enable not written"); // RL7

  property p_lock_defaults;
    @(posedge clk) disable iff (!rst_n_r)
    lock_r |=> ctrl_r == DEF_CTRL && scale_r == DEF_SCALE &&
      tmr_r == charger_cfg_pkg::DEF_TMR_SENS && volt_r == charger_cfg_pkg::DEF_VOLT_TEMP;
  endproperty
  a_lock_defaults: assert property (p_lock_defaults) else $error("defaults not restored"); // RL23

  property p_suspend;
    @(posedge clk) disable iff (!rst_n_r)
    input_limit_select == charger_cfg_pkg::LIMIT_SUSPEND |-> usb_suspend && !input_dynamic_path_management_enable;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend not entered"); // RL3

  property p_track_forces;
    @(posedge clk) disable iff (!rst_n_r)
    sys_rail_select == charger_cfg_pkg::SYS_TRACK_BAT |-> power_path_threshold_select && sys_track_battery;
  endproperty
  a_track_forces: assert property (p_track_forces) else $error("tracking did not force threshold"); // RL1

  property p_cmp_disabled;
    @(posedge clk) disable iff (!rst_n_r)
    reg_rd && reg_addr == charger_cfg_pkg::ADDR_VOLT_TEMP && !cell_comparator_enable |=> reg_rdata[0];
  endproperty
  a_cmp_disabled: assert property (p_cmp_disabled) else $error("comparator bit low while disabled"); // RL19

  property p_ro_bits;
    @(posedge clk) disable iff (!rst_n_r)
    reg_rd && reg_addr == charger_cfg_pkg::ADDR_TMR_SENS |=> reg_rdata[4] == 1'b0 && reg_rdata[0] == 1'b0;
  endproperty
  a_ro_bits: assert property (p_ro_bits) else $error("read-only bits not zero"); // RL21

  property p_state_read;
    @(posedge clk) disable iff (!rst_n_r)
    reg_rd && reg_addr == charger_cfg_pkg::ADDR_STATE |=> reg_rdata == $past(charger_state);
  endproperty
  a_state_read: assert property (p_state_read) else $error("state read mismatch"); // RL20

  property p_dynamic_path_management_code;
    @(posedge clk) disable iff (!rst_n_r)
    input_limit_select == charger_cfg_pkg::LIMIT_500_DYNAMIC_PATH_MANAGEMENT |-> input_dynamic_path_management_enable;
  endproperty
  a_dynamic_path_management_code: assert property (p_dynamic_path_management_code) else $error("input dynamic_path_management missing"); // RL2

  property p_scale_ro;
    @(posedge clk) disable iff (!rst_n_r)
    reg_rd && reg_addr == charger_cfg_pkg::ADDR_CUR_SCALE |=> reg_rdata[1:0] == RO_SCALE[1:0];
  endproperty
  a_scale_ro: assert property (p_scale_ro) else $error("scale read-only bits changed"); // RL21

  property p_scale_write;
    @(posedge clk) disable iff (!rst_n_r)
    reg_wr && !lock_r && reg_addr == charger_cfg_pkg::ADDR_CUR_SCALE |=> fastcharge_scale == $past(reg_wdata[5:4]);
  endproperty
  a_scale_write: assert property (p_scale_write) else $error("fast-charge scale not written"); // RL9

  property p_cmp_live;
    @(posedge clk) disable iff (!rst_n_r)
    reg_rd && reg_addr == charger_cfg_pkg::ADDR_VOLT_TEMP && cell_comparator_enable |=> reg_rdata[0] == $past(cmp_r);
  endproperty
  a_cmp_live: assert property (p_cmp_live) else $error("comparator bit not live"); // RL19

  property p_cov_suspend;
    @(posedge clk) disable iff (!rst_n_r) $rose(usb_suspend);
  endproperty
  c_cov_suspend: cover property (p_cov_suspend);

  property p_cov_lock;
    @(posedge clk) disable iff (!rst_n_r) lock_r ##1 !lock_r ##[1:20] reg_wr;
  endproperty
  c_cov_lock: cover property (p_cov_lock);

  property p_cov_cmp;
    @(posedge clk) disable iff (!rst_n_r) reg_rvalid && cmp_en && !cmp_bit;
  endproperty
  c_cov_cmp: cover property (p_cov_cmp);

  property p_cov_track;
    @(posedge clk) disable iff (!rst_n_r) $rose(sys_track_battery);
  endproperty
  c_cov_track: cover property (p_cov_track);

  property p_cov_state;
    @(posedge clk) disable iff (!rst_n_r) reg_rd && reg_addr == charger_cfg_pkg::ADDR_STATE ##1 reg_rvalid;
  endproperty
  c_cov_state: cover property (p_cov_state);
endmodule : charger_config_status_regs

// file: charger_side_model.sv
// Behavioural charger state logic that feeds the live state flags back to the bank
`timescale 1ns/1ps
module charger_side_model (
  input wire logic clk,
  input wire logic usb_suspend,
  input wire logic charger_enable,
  input wire logic fault_inject,
  output logic [7:0] charger_state
);
  always_ff @(posedge clk) begin
    if (usb_suspend) begin
      charger_state <= 8'h01;
    end else if (fault_inject) begin
      charger_state <= 8'h02;
    end else if (!charger_enable) begin
      charger_state <= 8'h20;
    end else begin
      charger_state <= 8'h08;
    end
  end
endmodule : charger_side_model

// file: tb_charger_config_status_regs.sv
// Self-checking testbench of the charger register bank
`timescale 1ns/1ps
module tb_charger_config_status_regs;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic supply_lockout = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cell_below_trip = 1'b0;
  logic fault_inject = 1'b0;
  logic [7:0] reg_rdata, charger_state;
  logic reg_rvalid, sys_track_battery, input_dynamic_path_management_enable, usb_suspend, thermal_regulation_enable;
  logic adaptive_timer_enable, termination_enable, charger_enable, precharge_timer_select, thermistor_type;
  logic power_path_threshold_select, cell_comparator_enable;
  logic [1:0] sys_rail_select, input_limit_select, precharge_factor, fastcharge_scale, termination_factor;
  logic [1:0] safety_timer_select, temp_window_offset, cell_trip_level;
  logic [2:0] charge_voltage_select;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  wire [7:0] ctrl_out = {sys_rail_select, input_limit_select, thermal_regulation_enable, adaptive_timer_enable,
    termination_enable, charger_enable};
  wire [7:0] scale_out = {precharge_factor, fastcharge_scale, termination_factor, 2'b00};
  wire [7:0] tmr_out = {safety_timer_select, precharge_timer_select, 1'b0, thermistor_type, 1'b0,
    cell_comparator_enable, 1'b0};
  wire [7:0] volt_out = {charge_voltage_select, temp_window_offset, cell_trip_level, 1'b0};
  wire [7:0] derived_out = {4'h0, sys_track_battery, input_dynamic_path_management_enable, usb_suspend, power_path_threshold_select};

  charger_config_status_regs #(.VARIANT(charger_cfg_pkg::VARIANT_BASE)) dut_u (
    .clk, .arst_n, .supply_lockout, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .charger_state, .cell_below_trip, .sys_rail_select, .sys_track_battery, .input_limit_select,
    .input_dynamic_path_management_enable, .usb_suspend, .thermal_regulation_enable, .adaptive_timer_enable, .termination_enable,
    .charger_enable, .precharge_factor, .fastcharge_scale, .termination_factor, .safety_timer_select,
    .precharge_timer_select, .thermistor_type, .power_path_threshold_select, .cell_comparator_enable,
    .charge_voltage_select, .temp_window_offset, .cell_trip_level
  );

  charger_side_model model_u (.clk, .usb_suspend, .charger_enable, .fault_inject, .charger_state);

  always #50 clk = ~clk;

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rvalid", {7'h00, reg_rvalid}, 8'h01);
    chk("rdata", reg_rdata, exp);
  endtask : rd

  initial begin
    logic [1:0] c;
    cyc(12);
    arst_n <= 1'b1;
    cyc(8);
    rd(8'h02, 8'h6F);
    rd(8'h03, 8'h54);
    rd(8'h04, 8'h4C);
    rd(8'h05, 8'h41);
    chk("ctrl", ctrl_out, 8'h6F);
    chk("derived", derived_out, 8'h01);
    $display("test defaults done");
    wr(8'h03, 8'hFF);
    wr(8'h04, 8'hFF);
    wr(8'h05, 8'hFF);
    chk("scale", scale_out, 8'hFC);
    chk("timer", tmr_out, 8'hEA);
    chk("volt", volt_out, 8'hFE);
    rd(8'h03, 8'hFC);
    rd(8'h04, 8'hEE);
    cyc(3);
    rd(8'h05, 8'hFE);
    @(posedge clk);
    cell_below_trip <= 1'b1;
    cyc(4);
    rd(8'h05, 8'hFF);
    @(posedge clk);
    cell_below_trip <= 1'b0;
    wr(8'h04, 8'h48);
    cyc(4);
    rd(8'h05, 8'hFF);
    $display("test fields done");
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(8'h02, {c, c, 4'hF});
      chk("ctrl", ctrl_out, {c, c, 4'hF});
      chk("derived", derived_out, {4'h0, c == 2'b00, c < 2'd2, c == 2'b11, c == 2'b00});
    end
    cyc(2);
    rd(8'h06, 8'h01);
    wr(8'h02, 8'h6E);
    cyc(2);
    rd(8'h06, 8'h20);
    wr(8'h02, 8'h6F);
    wr(8'h06, 8'hFF);
    cyc(2);
    rd(8'h06, 8'h08);
    @(posedge clk);
    fault_inject <= 1'b1;
    cyc(2);
    rd(8'h06, 8'h02);
    @(posedge clk);
    fault_inject <= 1'b0;
    $display("test state done");
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'hFF, 8'h00);
    $display("test unmapped done");
    wr(8'h02, 8'h81);
    chk("derived", derived_out, 8'h04);
    @(posedge clk);
    supply_lockout <= 1'b1;
    cyc(5);
    #1;
    chk("ctrl", ctrl_out, 8'h6F);
    chk("scale", scale_out, 8'h54);
    chk("volt", volt_out, 8'h40);
    chk("derived", derived_out, 8'h01);
    wr(8'h02, 8'h00);
    rd(8'h02, 8'h6F);
    rd(8'h04, 8'h4C);
    @(posedge clk);
    supply_lockout <= 1'b0;
    cyc(5);
    wr(8'h02, 8'h81);
    rd(8'h02, 8'h81);
    $display("test lockout done");
    @(posedge clk);
    arst_n <= 1'b0;
    cyc(3);
    #1;
    chk("ctrl", ctrl_out, 8'h6F);
    chk("derived", derived_out, 8'h01);
    chk("rvalid", {7'h00, reg_rvalid}, 8'h00);
    @(posedge clk);
    arst_n <= 1'b1;
    cyc(8);
    rd(8'h02, 8'h6F);
    $display("test reset done");
    conclude();
  end
endmodule : tb_charger_config_status_regs
